//--- design/rtc_gate.sv
/*
 * Access gating, timed windows, alarm match and flag of the real-time clock,
 * with a compact counter chain so the gating has something to hold.
 * Assumes a single 25 MHz clock, an Avalon-MM master and that software
 * keeps the machine-cycle spacing around hold changes.
 */
// Implementation choice: the Avalon-MM slave port.
module rtc_gate #(
    parameter int VALID_CYCLES = rtc_gate_pkg::VALID_CYC,
    parameter int CLEAR_CYCLES = rtc_gate_pkg::AUTO_CLEAR_CYC,
    parameter int TICK_CYCLES = rtc_gate_pkg::TICK_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Power-on reset without battery
    input wire logic nobat_rstn,
    // Register bus
    input wire rtc_gate_pkg::avmm_req_t avs_req,
    output rtc_gate_pkg::avmm_rsp_t avs_rsp,
    // Status
    output logic clock_irq,
    output logic read_valid,
    output logic write_valid
);
    import rtc_gate_pkg::*;

    // ****************************************
    // Bus decode
    // ****************************************
    logic [7:0] idx;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] wdat;
    logic ack_q;
    assign idx = avs_req.address[9:2];
    assign wdat = avs_req.writedata[7:0];
    // Writes land on the completing edge, the one where the master sees waitrequest low
    assign wr_hit = avs_req.write && avs_req.byteenable[0] && ack_q;
    assign rd_hit = avs_req.read && !ack_q;

    // One wait cycle per access so read data come from a flop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_req.read || avs_req.write) && !ack_q;
        end
    end
    assign avs_rsp.waitrequest = (avs_req.read || avs_req.write) && !ack_q;

    // ****************************************
    // Timed access unlock
    // ****************************************
    logic [1:0] ta_cnt_q;
    logic ta_open;
    logic ta_key1;
    logic ta_key2;
    logic ta_ctrl;
    // Unlock steps: first key, second key, then exactly one control write
    typedef enum logic [2:0] {
        TA_LOCKED = 3'b001,
        TA_KEYED = 3'b010,
        TA_OPEN = 3'b100
    } ta_state_t;
    ta_state_t ta_state_q;
    assign ta_key1 = wr_hit && idx == IDX_TA && wdat == TA_KEY1;
    assign ta_key2 = wr_hit && idx == IDX_TA && wdat == TA_KEY2;
    assign ta_ctrl = wr_hit && idx == IDX_CTRL;
    assign ta_open = (ta_state_q == TA_OPEN) && (ta_cnt_q != 2'h0);

    // Short window so a stray key write cannot unlock a much later control write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ta_cnt_q <= 2'h0;
        end else if (ta_key1 || (ta_key2 && ta_state_q == TA_KEYED)) begin
            ta_cnt_q <= 2'(TA_WINDOW);
        end else if (ta_cnt_q != 2'h0) begin
            ta_cnt_q <= ta_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ta_state_q <= TA_LOCKED;
        end else if (ta_key1) begin
            ta_state_q <= TA_KEYED;
        end else begin
            case (ta_state_q)
                TA_KEYED: begin
                    if (ta_key2) begin
                        ta_state_q <= TA_OPEN;
                    end else if (ta_ctrl || ta_cnt_q == 2'h0) begin
                        ta_state_q <= TA_LOCKED;
                    end
                end
                TA_OPEN: begin
                    if (ta_ctrl || ta_cnt_q == 2'h0) begin
                        ta_state_q <= TA_LOCKED;
                    end
                end
                default: begin
                    ta_state_q <= TA_LOCKED;
                end
            endcase
        end
    end

    // ****************************************
    // Hold bits and their windows
    // ****************************************
    logic read_hold_q;
    logic write_hold_q;
    logic [31:0] hold_cnt_q;
    logic ctrl_wr;
    logic both_set;
    logic hold_expire;
    assign ctrl_wr = wr_hit && idx == IDX_CTRL;
    assign both_set = wdat[BIT_READ_HOLD] && wdat[BIT_WRITE_HOLD];
    assign hold_expire = hold_cnt_q >= 32'(CLEAR_CYCLES - 1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            read_hold_q <= 1'b0;
        end else if (ctrl_wr && !both_set) begin
            read_hold_q <= wdat[BIT_READ_HOLD];
        end else if (read_hold_q && hold_expire) begin
            read_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_hold_q <= 1'b0;
        end else if (ctrl_wr && !both_set && ta_open) begin
            write_hold_q <= wdat[BIT_WRITE_HOLD];
        end else if (write_hold_q && hold_expire) begin
            write_hold_q <= 1'b0;
        end
    end

    // Window counter restarts when a hold is set while neither hold was set
    logic any_hold;
    logic hold_rise;
    logic any_hold_q;
    assign any_hold = read_hold_q || write_hold_q;
    assign hold_rise = any_hold && !any_hold_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            any_hold_q <= 1'b0;
            hold_cnt_q <= 32'h0;
        end else begin
            any_hold_q <= any_hold;
            if (!any_hold || hold_rise) begin
                hold_cnt_q <= 32'h0;
            end else if (!hold_expire) begin
                hold_cnt_q <= hold_cnt_q + 32'h1;
            end
        end
    end
    assign read_valid = read_hold_q && hold_cnt_q < 32'(VALID_CYCLES);
    assign write_valid = write_hold_q && hold_cnt_q < 32'(VALID_CYCLES);

    // ****************************************
    // Alarm enables, oscillator enable, interrupt enable
    // ****************************************
    // Alarm enables, alarm time and oscillator enable survive ordinary resets; only the no-battery reset touches them, while rstn clears the interrupt enable
    logic [3:0] cmp_en_q;
    logic osc_en_q;
    logic alarm_irq_enable_q;
    time_t alarm_q;
    always_ff @(posedge clk or negedge nobat_rstn) begin
        if (!nobat_rstn) begin
            cmp_en_q <= 4'h0;
            osc_en_q <= 1'b0;
            alarm_q <= '0;
        end else begin
            if (ctrl_wr) begin
                cmp_en_q <= wdat[7:4];
            end
            if (ctrl_wr && ta_open) begin
                osc_en_q <= wdat[BIT_OSC_EN];
            end
            if (wr_hit && idx == IDX_ALARM_SUBSEC) begin
                alarm_q.subsec <= wdat;
            end
            if (wr_hit && idx == IDX_ALARM_SEC) begin
                alarm_q.sec <= wdat;
            end
            if (wr_hit && idx == IDX_ALARM_MIN) begin
                alarm_q.min <= wdat;
            end
            if (wr_hit && idx == IDX_ALARM_HOUR) begin
                alarm_q.hour <= wdat;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alarm_irq_enable_q <= 1'b0;
        end else if (wr_hit && idx == IDX_IRQ_EN) begin
            alarm_irq_enable_q <= wdat[BIT_ALARM_IRQ_EN];
        end
    end

    // ****************************************
    // Counter chain
    // ****************************************
    time_t live_q;
    time_t shadow_q;
    logic [31:0] div_q;
    logic tick;
    assign tick = osc_en_q && div_q >= 32'(TICK_CYCLES - 1);

    // The divider keeps running during a write hold; ticks are banked so no time is lost
    logic [7:0] owed_q;
    always_ff @(posedge clk or negedge nobat_rstn) begin
        if (!nobat_rstn) begin
            div_q <= 32'h0;
        end else if (!osc_en_q || tick) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end

    logic step;
    logic write_hold_fall;
    logic wh_q;
    logic bank;
    // The cycle that loads 00h cannot step, so its tick is banked too
    assign write_hold_fall = wh_q && !write_hold_q;
    assign bank = write_hold_q || write_hold_fall;
    assign step = !bank && (tick || owed_q != 8'h0);

    function automatic time_t advance(input time_t t);
        time_t n;
        n = t;
        if (t.subsec == 8'(SUBSEC_MAX)) begin
            n.subsec = 8'h00;
            if (t.sec == 8'(SEC_MAX)) begin
                n.sec = 8'h00;
                if (t.min == 8'(SEC_MAX)) begin
                    n.min = 8'h00;
                    if (t.hour == 8'(HOUR_MAX)) begin
                        n.hour = 8'h00;
                        n.day = t.day + 16'h1;
                    end else begin
                        n.hour = t.hour + 8'h1;
                    end
                end else begin
                    n.min = t.min + 8'h1;
                end
            end else begin
                n.sec = t.sec + 8'h1;
            end
        end else begin
            n.subsec = t.subsec + 8'h1;
        end
        return n;
    endfunction : advance

    always_ff @(posedge clk or negedge nobat_rstn) begin
        if (!nobat_rstn) begin
            owed_q <= 8'h00;
        end else if (bank && tick) begin
            owed_q <= owed_q + 8'h1;
        end else if (step && !tick) begin
            owed_q <= owed_q - 8'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wh_q <= 1'b0;
        end else begin
            wh_q <= write_hold_q;
        end
    end

    always_ff @(posedge clk or negedge nobat_rstn) begin
        if (!nobat_rstn) begin
            live_q <= '0;
        end else if (write_hold_fall) begin
            live_q.subsec <= 8'h00;
        end else if (write_valid && wr_hit) begin
            if (idx == IDX_SUBSEC) begin
                live_q.subsec <= wdat;
            end else if (idx == IDX_SEC) begin
                live_q.sec <= wdat;
            end else if (idx == IDX_MIN) begin
                live_q.min <= wdat;
            end else if (idx == IDX_HOUR) begin
                live_q.hour <= wdat;
            end else if (idx == IDX_DAY_LO) begin
                live_q.day[7:0] <= wdat;
            end else if (idx == IDX_DAY_HI) begin
                live_q.day[15:8] <= wdat;
            end
        end else if (step) begin
            live_q <= advance(live_q);
        end
    end

    // Visible copy stops following while read hold is set
    always_ff @(posedge clk or negedge nobat_rstn) begin
        if (!nobat_rstn) begin
            shadow_q <= '0;
        end else if (!read_hold_q) begin
            shadow_q <= live_q;
        end
    end

    // ****************************************
    // Alarm match and flag
    // ****************************************
    logic match;
    logic match_q;
    logic alarm_flag_q;
    assign match = (cmp_en_q != 4'h0) &&
        (!cmp_en_q[3] || alarm_q.subsec == live_q.subsec) &&
        (!cmp_en_q[2] || alarm_q.sec == live_q.sec) &&
        (!cmp_en_q[1] || alarm_q.min == live_q.min) &&
        (!cmp_en_q[0] || alarm_q.hour == live_q.hour);

    always_ff @(posedge clk or negedge nobat_rstn) begin
        if (!nobat_rstn) begin
            match_q <= 1'b0;
            alarm_flag_q <= 1'b0;
        end else begin
            match_q <= match;
            if (match && !match_q) begin
                alarm_flag_q <= 1'b1;
            end else if (ctrl_wr && wdat[7:4] == 4'h0) begin
                alarm_flag_q <= 1'b0;
            end else if (ctrl_wr && !wdat[BIT_ALARM_FLAG]) begin
                alarm_flag_q <= 1'b0;
            end
        end
    end
    // Ordinary reset leaves the flag alone; of the two resets only the no-battery reset clears it
    assign clock_irq = alarm_flag_q && alarm_irq_enable_q;

    // ****************************************
    // Read data
    // ****************************************
    logic [7:0] rdat_d;
    logic [31:0] rdat_q;
    always_comb begin
        rdat_d = 8'h00;
        if (idx == IDX_SUBSEC) rdat_d = shadow_q.subsec;
        else if (idx == IDX_SEC) rdat_d = shadow_q.sec;
        else if (idx == IDX_MIN) rdat_d = shadow_q.min;
        else if (idx == IDX_HOUR) rdat_d = shadow_q.hour;
        else if (idx == IDX_DAY_LO) rdat_d = shadow_q.day[7:0];
        else if (idx == IDX_DAY_HI) rdat_d = shadow_q.day[15:8];
        else if (idx == IDX_CTRL) rdat_d = {cmp_en_q, read_hold_q, write_hold_q,
            alarm_flag_q, osc_en_q};
        else if (idx == IDX_ALARM_SUBSEC) rdat_d = alarm_q.subsec;
        else if (idx == IDX_ALARM_SEC) rdat_d = alarm_q.sec;
        else if (idx == IDX_ALARM_MIN) rdat_d = alarm_q.min;
        else if (idx == IDX_ALARM_HOUR) rdat_d = alarm_q.hour;
        else if (idx == IDX_IRQ_EN) rdat_d = {2'h0, alarm_irq_enable_q, 5'h00};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdat_q <= 32'h0;
        end else if (rd_hit) begin
            rdat_q <= {24'h0, rdat_d};
        end
    end
    assign avs_rsp.readdata = rdat_q;

endmodule : rtc_gate

//--- design/rtc_gate_pkg.sv
/*
 * Constants, register map and carrier types for the real-time clock access-gating block.
 * Assumes a 25 MHz system clock and an Avalon-MM slave port with 32-bit data.
 */
package rtc_gate_pkg;

    // ****************************************
    // Register map (register indices; byte address is four times the index)
    // ****************************************
    localparam logic [7:0] IDX_SUBSEC = 8'hfa;
    localparam logic [7:0] IDX_SEC = 8'hfb;
    localparam logic [7:0] IDX_MIN = 8'hfc;
    localparam logic [7:0] IDX_HOUR = 8'hfd;
    localparam logic [7:0] IDX_DAY_LO = 8'hfe;
    localparam logic [7:0] IDX_DAY_HI = 8'hff;
    localparam logic [7:0] IDX_CTRL = 8'hf9;
    localparam logic [7:0] IDX_ALARM_SUBSEC = 8'hf2;
    localparam logic [7:0] IDX_ALARM_SEC = 8'hf3;
    localparam logic [7:0] IDX_ALARM_MIN = 8'hf4;
    localparam logic [7:0] IDX_ALARM_HOUR = 8'hf5;
    localparam logic [7:0] IDX_IRQ_EN = 8'he8;
    localparam logic [7:0] IDX_TA = 8'hc7;

    // ****************************************
    // Control register fields, plus the alarm interrupt-enable bit of the interrupt-enable register
    // ****************************************
    localparam int BIT_SUBSEC_CE = 7;
    localparam int BIT_SEC_CE = 6;
    localparam int BIT_MIN_CE = 5;
    localparam int BIT_HOUR_CE = 4;
    localparam int BIT_READ_HOLD = 3;
    localparam int BIT_WRITE_HOLD = 2;
    localparam int BIT_ALARM_FLAG = 1;
    localparam int BIT_OSC_EN = 0;
    localparam int BIT_ALARM_IRQ_EN = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ****************************************
    // Timed-access unlock
    // ****************************************
    localparam logic [7:0] TA_KEY1 = 8'haa;
    localparam logic [7:0] TA_KEY2 = 8'h55;
    localparam int TA_WINDOW = 3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int VALID_US = 1000;
    localparam int AUTO_CLEAR_US = 1950;
    localparam int VALID_CYC = VALID_US * (CLK_HZ / 1000000);
    localparam int AUTO_CLEAR_CYC = AUTO_CLEAR_US * (CLK_HZ / 1000000);
    localparam int TICK_DIV = CLK_HZ / 256;
    localparam int SUBSEC_MAX = 255;
    localparam int SEC_MAX = 59;
    localparam int HOUR_MAX = 23;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic [7:0] subsec;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [15:0] day;
    } time_t;

    typedef struct packed {
        logic [9:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_t;

endpackage : rtc_gate_pkg

//--- sim/rtc_gate_checker.sv
/*
 * Port-level assertions for the clock access-gating block.
 * Assumes it is bound to the top module and handed the read window length.
 */
module rtc_gate_checker #(
    parameter int VALID_CYCLES = 50
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic nobat_rstn,
    // Register bus
    input wire rtc_gate_pkg::avmm_req_t avs_req,
    input wire rtc_gate_pkg::avmm_rsp_t avs_rsp,
    // Status
    input wire logic clock_irq,
    input wire logic read_valid,
    input wire logic write_valid
);
    import rtc_gate_pkg::*;

    // ****
    // Helper logic
    // ****
    // Run lengths catch a window that never closes
    logic [15:0] rd_run_q;
    logic [15:0] wr_run_q;
    logic bus_done;
    logic ctrl_wr;
    assign bus_done = (avs_req.read || avs_req.write) && !avs_rsp.waitrequest;
    assign ctrl_wr = bus_done && avs_req.write && (avs_req.address[9:2] == IDX_CTRL);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_run_q <= 16'h0000;
        end else begin
            rd_run_q <= read_valid ? rd_run_q + 16'h0001 : 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_run_q <= 16'h0000;
        end else begin
            wr_run_q <= write_valid ? wr_run_q + 16'h0001 : 16'h0000;
        end
    end

    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn || !nobat_rstn);

    sequence req_start;
        $rose(avs_req.read || avs_req.write);
    endsequence
    sequence one_wait;
        avs_rsp.waitrequest ##1 !avs_rsp.waitrequest;
    endsequence

    a_wait_one_cycle: assert property (req_start |-> one_wait)
        else $error("request not answered after one wait cycle");
    a_holds_exclusive: assert property (!(read_valid && write_valid))
        else $error("read and write windows open together");
    a_read_window_len: assert property (read_valid |-> rd_run_q <= VALID_CYCLES)
        else $error("read window too long");
    a_write_window_len: assert property (write_valid |-> wr_run_q <= VALID_CYCLES)
        else $error("write window too long");
    a_read_open_cause: assert property ($rose(read_valid) |-> $past(ctrl_wr))
        else $error("read window opened without a control write");
    a_write_open_cause: assert property ($rose(write_valid) |-> $past(ctrl_wr))
        else $error("write window opened without a control write");
    a_irq_fall_cause: assert property (
        $fell(clock_irq) |-> $past(bus_done && avs_req.write))
        else $error("interrupt dropped without a write");
    a_irq_no_sw_set: assert property (
        ctrl_wr && avs_req.writedata[BIT_ALARM_FLAG] |=> !$rose(clock_irq))
        else $error("software flag write raised the interrupt");
    a_reset_clears_holds: assert property (@(posedge clk) disable iff (!nobat_rstn)
        !rstn |-> !read_valid && !write_valid)
        else $error("hold window open during reset");
endmodule : rtc_gate_checker

//--- sim/test_rtc_gate.sv
/*
 * Self-checking bench for the clock access-gating block.
 * Assumes shortened window parameters and a bus master built from tasks.
 */
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_rtc_gate;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_gate_pkg::*;

    logic clk, rstn, nobat_rstn, clock_irq, read_valid, write_valid;
    avmm_req_t req;
    avmm_rsp_t rsp;
    int num_errors = 0;
    int comparisons = 0;
    logic [7:0] q, s0;
    logic [7:0] tv [5] = '{8'h40, 8'h12, 8'h34, 8'h05, 8'h01};

    rtc_gate #(.VALID_CYCLES(50), .CLEAR_CYCLES(100), .TICK_CYCLES(8)) dut (
        .clk(clk), .rstn(rstn), .nobat_rstn(nobat_rstn), .avs_req(req), .avs_rsp(rsp),
        .clock_irq(clock_irq), .read_valid(read_valid), .write_valid(write_valid));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****
    // Bus tasks
    // ****
    // Request stays up after the answer so transfers can run back to back
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        req.read <= !wr;
        req.write <= wr;
        req.address <= {idx, 2'b00};
        req.writedata <= {24'h000000, d};
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata[7:0];
    endtask : xfer
    task automatic idle(input int c);
        req.read <= 1'b0;
        req.write <= 1'b0;
        repeat (c) @(posedge clk);
    endtask : idle
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
        idle(1);
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        xfer(1'b0, idx, 8'h00);
        idle(1);
    endtask : rd
    task automatic ta(input logic [7:0] d);
        xfer(1'b1, IDX_TA, TA_KEY1);
        xfer(1'b1, IDX_TA, TA_KEY2);
        xfer(1'b1, IDX_CTRL, d);
        idle(1);
    endtask : ta
    task automatic wait_irq();
        for (int n = 0; n < 2300 && clock_irq !== 1'b1; n++) @(posedge clk);
    endtask : wait_irq
    task automatic tally_and_finish();
        $display("Mismatches %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // ****
    // Tests
    // ****
    initial begin
        rstn = 1'b0;
        nobat_rstn = 1'b0;
        req = '0;
        req.byteenable = 4'hf;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        nobat_rstn <= 1'b1;
        @(posedge clk);
        rd(IDX_CTRL);
        `CHK(q, CTRL_RESET)
        wr(8'h10, 8'h5a);
        rd(8'h10);
        `CHK(q, 8'h00)
        ta(8'h0c);
        rd(IDX_CTRL);
        `CHK(q[3:2], 2'b00)
        wr(IDX_CTRL, 8'h04);
        `CHK(write_valid, 1'b0)
        ta(8'h05);
        `CHK(write_valid, 1'b1)
        idle(4);
        for (int i = 0; i < 5; i++) wr(IDX_SUBSEC + 8'(i), tv[i]);
        ta(8'h01);
        idle(4);
        wr(IDX_SEC, 8'h33);
        wr(IDX_CTRL, 8'h09);
        `CHK(read_valid, 1'b1)
        idle(4);
        for (int i = 1; i < 5; i++) begin
            rd(IDX_SUBSEC + 8'(i));
            `CHK(q, tv[i])
        end
        rd(IDX_SUBSEC);
        `CHK(q < 8'h10, 1'b1)
        s0 = q;
        idle(16);
        rd(IDX_SUBSEC);
        `CHK(q, s0)
        idle(30);
        `CHK(read_valid, 1'b0)
        idle(40);
        rd(IDX_CTRL);
        `CHK(q[3], 1'b0)
        idle(4);
        wr(IDX_CTRL, 8'h09);
        idle(4);
        rd(IDX_SUBSEC);
        `CHK(q > s0, 1'b1)
        wr(IDX_CTRL, 8'h01);
        idle(4);
        ta(8'h05);
        idle(110);
        rd(IDX_CTRL);
        `CHK(q[2], 1'b0)
        idle(4);
        // Only the subsecond compare is on, so the other fields are ignored
        wr(IDX_ALARM_SUBSEC, 8'h20);
        wr(IDX_IRQ_EN, 8'h20);
        wr(IDX_CTRL, 8'h80);
        wait_irq();
        `CHK(clock_irq, 1'b1)
        rd(IDX_CTRL);
        `CHK(q[1], 1'b1)
        wr(IDX_CTRL, 8'h80);
        `CHK(clock_irq, 1'b0)
        wr(IDX_CTRL, 8'h82);
        `CHK(clock_irq, 1'b0)
        rd(IDX_CTRL);
        `CHK(q[1], 1'b0)
        wait_irq();
        wr(IDX_IRQ_EN, 8'h00);
        `CHK(clock_irq, 1'b0)
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(IDX_CTRL);
        `CHK(q[1], 1'b1)
        `CHK(q[3:2], 2'b00)
        wr(IDX_IRQ_EN, 8'h20);
        `CHK(clock_irq, 1'b1)
        wr(IDX_CTRL, 8'h02);
        `CHK(clock_irq, 1'b0)
        rd(IDX_CTRL);
        `CHK(q[1], 1'b0)
        tally_and_finish();
    end

    // Two alarm waits dominate the run length
    initial begin
        repeat (12000) @(posedge clk);
        num_errors++;
        $display("Watchdog expired");
        tally_and_finish();
    end
endmodule : test_rtc_gate

bind rtc_gate rtc_gate_checker #(.VALID_CYCLES(VALID_CYCLES)) u_chk (
    .clk(clk), .rstn(rstn), .nobat_rstn(nobat_rstn), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .clock_irq(clock_irq), .read_valid(read_valid), .write_valid(write_valid));
